/* src/parallel_byte_fifo_port.sv */
// Parallel byte port with asynchronous and synchronous strobe modes.
`timescale 1ns/100ps

module parallel_byte_fifo_port
  import byte_port_pkg::*;
#(
  parameter int DW = BYTE_W
)
(
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Link clock, forwarded to clkOut in both modes.
  input wire logic linkClk,
  // Mode configuration, high for synchronous mode.
  input wire logic syncModeSel,
  // Receive bytes from the device side.
  input wire logic [DW-1:0] rxData,
  input wire logic rxValid,
  output logic rxReady,
  // Transmit bytes to the device side.
  output logic [DW-1:0] txData,
  output logic txValid,
  input wire logic txReady,
  // Strobes and output enable from the outside party.
  input wire logic rdN,
  input wire logic wrN,
  input wire logic oeN,
  // Data lines.
  input wire logic [DW-1:0] dataIn,
  output logic [DW-1:0] dataOut,
  output logic dataOe,
  // Flow-control flags and clock output.
  output logic rxfN,
  output logic txeN,
  output logic clkOut
);

  initial
  begin
    if (DW < 1 || FLAG_IDLE_CYC >= (1 << GAP_W))
    begin
      $error("Unsupported data width or idle count.");
    end
  end

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] rdPipe;
    logic [SYNC_DEPTH-1:0] wrPipe;
    logic [DW-1:0] dPipe0;
    logic [DW-1:0] dPipe1;
    logic rdLast;
    logic wrLast;
    logic syncMode;
    logic [DW-1:0] rxHold;
    logic rxHeld;
    logic rxSent;
    logic rxReqTgl;
    logic [DW-1:0] outByte;
    logic rxfN;
    logic [GAP_W-1:0] rxGap;
    logic [DW-1:0] txHold;
    logic txHeld;
    logic txeN;
    logic [GAP_W-1:0] txGap;
    logic txAckTgl;
    logic [SYNC_DEPTH-1:0] rxAckPipe;
    logic [SYNC_DEPTH-1:0] txReqPipe;
  } core_s;

  localparam core_s CORE_RESET = '{
    rdPipe: {SYNC_DEPTH{STROBE_IDLE}},
    wrPipe: {SYNC_DEPTH{STROBE_IDLE}},
    rdLast: STROBE_IDLE,
    wrLast: STROBE_IDLE,
    rxfN: FLAG_IDLE,
    txeN: FLAG_IDLE,
    default: '0
  };

  // Reports a high-to-low change of an active-low strobe.
  function automatic logic fell(input logic last, input logic now);
    fell = last && !now;
  endfunction : fell

  core_s st;
  core_s next_st;
  logic rdS;
  logic wrS;
  logic rdFall;
  logic rdRise;
  logic wrFall;
  logic wrRise;
  logic txPending;
  logic [DW-1:0] linkDataOut;
  logic linkDataOe;
  logic linkRxfN;
  logic linkTxeN;

  link_xfer_if #(.DW(DW)) xfer ();

  assign rdS = st.rdPipe[1];
  assign wrS = st.wrPipe[1];
  assign rdFall = fell(st.rdLast, rdS);
  assign rdRise = fell(rdS, st.rdLast);
  assign wrFall = fell(st.wrLast, wrS);
  assign wrRise = fell(wrS, st.wrLast);
  assign txPending = st.txReqPipe[1] != st.txAckTgl;

  always_comb
  begin
    next_st = st;
    next_st.rdPipe = {st.rdPipe[0], rdN};
    next_st.wrPipe = {st.wrPipe[0], wrN};
    next_st.dPipe0 = dataIn;
    next_st.dPipe1 = st.dPipe0;
    next_st.rdLast = rdS;
    next_st.wrLast = wrS;
    next_st.rxAckPipe = {st.rxAckPipe[0], xfer.rxAckTgl};
    next_st.txReqPipe = {st.txReqPipe[0], xfer.txReqTgl};
    // Mode follows its configuration only while the port is idle.
    if (rdS && wrS && !st.rxSent && !txPending)
    begin
      next_st.syncMode = syncModeSel;
    end
    // Device side loads the receive holding register when it is free.
    if (rxValid && !st.rxHeld)
    begin
      next_st.rxHold = rxData;
      next_st.rxHeld = 1'h1;
    end
    // Device side drains the transmit holding register.
    if (txReady && st.txHeld)
    begin
      next_st.txHeld = 1'h0;
    end
    if (!st.syncMode)
    begin
      // Falling read strobe presents the held byte and frees the register.
      if (rdFall && st.rxHeld && !st.rxfN)
      begin
        next_st.outByte = st.rxHold;
        next_st.rxHeld = 1'h0;
      end
      if (rdRise)
      begin
        next_st.rxfN = FLAG_IDLE;
        next_st.rxGap = GAP_LOAD;
      end
      else if (st.rxGap != '0)
      begin
        next_st.rxGap = st.rxGap - GAP_W'(1);
      end
      else if (rdS && st.rxHeld)
      begin
        next_st.rxfN = 1'h0;
      end
      // Falling write strobe captures the data lines if there is room.
      if (wrFall)
      begin
        next_st.txeN = FLAG_IDLE;
        if (!st.txeN && !st.txHeld)
        begin
          next_st.txHold = st.dPipe1;
          next_st.txHeld = 1'h1;
        end
      end
      if (wrRise)
      begin
        next_st.txGap = GAP_LOAD;
      end
      else if (st.txGap != '0)
      begin
        next_st.txGap = st.txGap - GAP_W'(1);
      end
      else if (wrS && !st.txHeld && !(txReady && st.txHeld))
      begin
        next_st.txeN = 1'h0;
      end
    end
    else
    begin
      next_st.rxfN = FLAG_IDLE;
      next_st.txeN = FLAG_IDLE;
      // Held receive byte is offered to the link with a request toggle.
      if (st.rxHeld && !st.rxSent)
      begin
        next_st.rxReqTgl = ~st.rxReqTgl;
        next_st.rxSent = 1'h1;
      end
      if (st.rxSent && st.rxAckPipe[1] == st.rxReqTgl)
      begin
        next_st.rxHeld = 1'h0;
        next_st.rxSent = 1'h0;
      end
      // A byte written on the link is taken once the register is free.
      if (txPending && !st.txHeld)
      begin
        next_st.txHold = xfer.txWord;
        next_st.txHeld = 1'h1;
        next_st.txAckTgl = ~st.txAckTgl;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= CORE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign xfer.syncMode = st.syncMode;
  assign xfer.rxWord = st.rxHold;
  assign xfer.rxReqTgl = st.rxReqTgl;
  assign xfer.txAckTgl = st.txAckTgl;

  sync_link_engine #(.DW(DW)) u_link (
    .linkClk(linkClk),
    .rst_n(rst_n),
    .xfer(xfer),
    .rdN(rdN),
    .wrN(wrN),
    .oeN(oeN),
    .dataIn(dataIn),
    .dataOut(linkDataOut),
    .dataOe(linkDataOe),
    .rxfN(linkRxfN),
    .txeN(linkTxeN)
  );

  // Data, enable and flag pin outputs select the logic of the active mode.
  assign dataOut = st.syncMode ? linkDataOut : st.outByte;
  assign dataOe = st.syncMode ? linkDataOe : !rdS;
  assign rxfN = st.syncMode ? linkRxfN : st.rxfN;
  assign txeN = st.syncMode ? linkTxeN : st.txeN;
  assign clkOut = linkClk;
  assign rxReady = !st.rxHeld;
  assign txValid = st.txHeld;
  assign txData = st.txHold;

  property p_rx_flag_rise;
    @(posedge core_clk) disable iff (!rst_n)
      rdRise && !st.syncMode |=> st.rxfN [*8];
  endproperty
  a_rx_flag_rise: assert property (p_rx_flag_rise)
    else $error("Receive flag not held high after read strobe rose.");

  property p_tx_flag_rise;
    @(posedge core_clk) disable iff (!rst_n)
      wrFall && !st.syncMode |=> st.txeN ##1 st.txeN;
  endproperty
  a_tx_flag_rise: assert property (p_tx_flag_rise)
    else $error("Transmit flag not raised by falling write strobe.");

  property p_fetch;
    @(posedge core_clk) disable iff (!rst_n)
      rdFall && !st.syncMode && !st.rxfN |=> st.outByte == $past(st.rxHold);
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("Read strobe did not fetch the held byte.");

  property p_capture;
    @(posedge core_clk) disable iff (!rst_n)
      wrFall && !st.syncMode && !st.txeN && !st.txHeld
      |=> st.txHeld && st.txHold == $past(st.dPipe1);
  endproperty
  a_capture: assert property (p_capture)
    else $error("Write strobe did not capture the data lines.");

  property p_no_overwrite;
    @(posedge core_clk) disable iff (!rst_n)
      st.txHeld && !txReady |=> $stable(st.txHold);
  endproperty
  a_no_overwrite: assert property (p_no_overwrite)
    else $error("Transmit byte overwritten while held.");

  property p_mode_steady;
    @(posedge core_clk) disable iff (!rst_n)
      !rdS || !wrS |=> $stable(st.syncMode);
  endproperty
  a_mode_steady: assert property (p_mode_steady)
    else $error("Mode changed during a strobe.");

endmodule : parallel_byte_fifo_port

/* src/byte_port_pkg.sv */
// Shared constants for the parallel byte port.
package byte_port_pkg;

  // Width of the parallel data lines.
  localparam int BYTE_W = 8;

  // Core clock rate and the least time a flag stays inactive after a strobe cycle.
  localparam int CORE_CLK_MHZ = 125;
  localparam int FLAG_IDLE_NS = 100;
  localparam int FLAG_IDLE_CYC = (FLAG_IDLE_NS * CORE_CLK_MHZ + 999) / 1000;

  // Width of the flag idle counter and its load value.
  localparam int GAP_W = 4;
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(FLAG_IDLE_CYC);

  // Idle levels of the active-low strobes and flags.
  localparam logic STROBE_IDLE = 1'h1;
  localparam logic FLAG_IDLE = 1'h1;

  // Depth of a two-flop synchroniser.
  localparam int SYNC_DEPTH = 2;

endpackage : byte_port_pkg

/* src/link_xfer_if.sv */
// Mode, byte and toggle signals passed between the core domain and the link domain.
`timescale 1ns/100ps
interface link_xfer_if #(parameter int DW = 8);
  logic syncMode;
  logic [DW-1:0] rxWord;
  logic rxReqTgl;
  logic rxAckTgl;
  logic [DW-1:0] txWord;
  logic txReqTgl;
  logic txAckTgl;

  modport core (
    output syncMode,
    output rxWord,
    output rxReqTgl,
    output txAckTgl,
    input rxAckTgl,
    input txWord,
    input txReqTgl
  );

  modport link (
    input syncMode,
    input rxWord,
    input rxReqTgl,
    input txAckTgl,
    output rxAckTgl,
    output txWord,
    output txReqTgl
  );
endinterface : link_xfer_if

/* src/sync_link_engine.sv */
// Synchronous-mode port logic running on the link clock.
`timescale 1ns/100ps
module sync_link_engine
  import byte_port_pkg::*;
#(
  parameter int DW = BYTE_W
)
(
  // Link clock and reset.
  input wire logic linkClk,
  input wire logic rst_n,
  // Crossing to the core domain.
  link_xfer_if.link xfer,
  // Pins, synchronous to the forwarded clock.
  input wire logic rdN,
  input wire logic wrN,
  input wire logic oeN,
  input wire logic [DW-1:0] dataIn,
  output logic [DW-1:0] dataOut,
  output logic dataOe,
  output logic rxfN,
  output logic txeN
);

  typedef struct packed {
    logic [SYNC_DEPTH-1:0] modePipe;
    logic [SYNC_DEPTH-1:0] rxReqPipe;
    logic [SYNC_DEPTH-1:0] txAckPipe;
    logic [DW-1:0] rxByte;
    logic rxFull;
    logic rxAckTgl;
    logic [DW-1:0] txByte;
    logic txFull;
    logic txReqTgl;
  } link_s;

  link_s st;
  link_s next_st;
  logic mode;

  assign mode = st.modePipe[1];

  always_comb
  begin
    next_st = st;
    next_st.modePipe = {st.modePipe[0], xfer.syncMode};
    next_st.rxReqPipe = {st.rxReqPipe[0], xfer.rxReqTgl};
    next_st.txAckPipe = {st.txAckPipe[0], xfer.txAckTgl};
    // A new receive byte is taken only into an empty holding register.
    if (st.rxReqPipe[1] != st.rxAckTgl && !st.rxFull)
    begin
      next_st.rxByte = xfer.rxWord;
      next_st.rxFull = 1'h1;
      next_st.rxAckTgl = ~st.rxAckTgl;
    end
    // A held byte leaves on the next clock edge while the read strobe is held low.
    if (mode && !rdN && st.rxFull)
    begin
      next_st.rxFull = 1'h0;
    end
    if (st.txFull && st.txAckPipe[1] == st.txReqTgl)
    begin
      next_st.txFull = 1'h0;
    end
    // A byte enters on the next clock edge while the write strobe is held low and the register is empty.
    if (mode && !wrN && !st.txFull)
    begin
      next_st.txByte = dataIn;
      next_st.txFull = 1'h1;
      next_st.txReqTgl = ~st.txReqTgl;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dataOut = st.rxByte;
  assign dataOe = mode && !oeN;
  assign rxfN = !(mode && st.rxFull);
  assign txeN = !(mode && !st.txFull);
  assign xfer.rxAckTgl = st.rxAckTgl;
  assign xfer.txWord = st.txByte;
  assign xfer.txReqTgl = st.txReqTgl;

  property p_burst_read;
    @(posedge linkClk) disable iff (!rst_n)
      mode && !rdN && st.rxFull && st.rxReqPipe[1] == st.rxAckTgl |=> rxfN;
  endproperty
  a_burst_read: assert property (p_burst_read)
    else $error("Read byte not consumed on the clock edge.");

  property p_burst_write;
    @(posedge linkClk) disable iff (!rst_n)
      mode && !wrN && !txeN |=> txeN && st.txByte == $past(dataIn);
  endproperty
  a_burst_write: assert property (p_burst_write)
    else $error("Written byte not captured on the clock edge.");

  property p_full_hold;
    @(posedge linkClk) disable iff (!rst_n)
      st.txFull && st.txAckPipe[1] != st.txReqTgl |=> $stable(st.txByte);
  endproperty
  a_full_hold: assert property (p_full_hold)
    else $error("Transmit byte overwritten while full.");

endmodule : sync_link_engine

/* verif/host_strobe_model.sv */
// Outside party model driving the strobes and the data lines.
`timescale 1ns/100ps
module host_strobe_model
  import byte_port_pkg::*;
(
  // Clocks.
  input wire logic core_clk,
  input wire logic clkOut,
  // Device pins.
  input wire logic rxfN,
  input wire logic txeN,
  input wire logic [BYTE_W-1:0] dataOut,
  input wire logic dataOe,
  output logic rdN,
  output logic wrN,
  output logic oeN,
  output logic [BYTE_W-1:0] dataIn
);
  logic drv = 1'h0;
  logic [BYTE_W-1:0] val = 8'h5A;
  logic stall = 1'h0;
  // A released line shows dataOut while dataOe is high, else the inverse of the last byte.
  assign dataIn = drv ? val : (dataOe ? dataOut : ~val);
  initial
  begin
    rdN = 1'h1;
    wrN = 1'h1;
    oeN = 1'h1;
  end
  task automatic tick(input logic s);
    if (s)
      @(negedge clkOut);
    else
      @(negedge core_clk);
  endtask : tick
  task automatic waitFlag(input logic s, input logic tx);
    int n;
    n = 0;
    while ((tx ? txeN : rxfN) !== 1'h0 && n < 500)
    begin
      tick(s);
      n++;
    end
    if (n >= 500)
      stall = 1'h1;
  endtask : waitFlag
  task automatic readByte(input logic s, input logic skip, output logic [BYTE_W-1:0] b,
    output logic oe);
    if (!skip)
      waitFlag(s, 1'h0);
    oeN = ~s;
    tick(s);
    rdN = 1'h0;
    repeat (s ? 1 : 5) tick(s);
    b = dataOut;
    oe = dataOe;
    rdN = 1'h1;
    oeN = 1'h1;
    tick(s);
  endtask : readByte
  task automatic writeByte(input logic s, input logic [BYTE_W-1:0] b);
    waitFlag(s, 1'h1);
    val = b;
    drv = 1'h1;
    wrN = 1'h0;
    repeat (s ? 1 : 5) tick(s);
    wrN = 1'h1;
    repeat (3) tick(s);
    drv = 1'h0;
  endtask : writeByte
endmodule : host_strobe_model

/* verif/test_parallel_byte_fifo_port.sv */
// Self-checking bench for the parallel byte port.
`timescale 1ns/100ps
module test_parallel_byte_fifo_port;
  import byte_port_pkg::*;
  typedef struct packed
  {
    logic m;
    logic [BYTE_W-1:0] rx;
    logic [BYTE_W-1:0] tx;
  } row_s;
  localparam row_s ROWS [6] = '{'{1'h0, 8'h00, 8'hFF}, '{1'h0, 8'hA5, 8'h01},
    '{1'h1, 8'h3C, 8'h80}, '{1'h1, 8'hFF, 8'h00}, '{1'h0, 8'h81, 8'h7E},
    '{1'h1, 8'h5A, 8'hC3}};
  logic core_clk = 1'h0;
  logic linkClk = 1'h0;
  logic rst_n = 1'h0;
  logic syncModeSel = 1'h0;
  logic rxValid = 1'h0;
  logic txReady = 1'h0;
  logic [BYTE_W-1:0] rxData = 8'h00;
  logic [BYTE_W-1:0] txData, dataIn, dataOut, rdB;
  logic rxReady, txValid, rdN, wrN, oeN, dataOe, rxfN, txeN, clkOut, rdOe;
  int errors = 0;
  int num_checks = 0;
  always #4 core_clk = ~core_clk;
  initial
  begin
    #3;
    forever #7.5 linkClk = ~linkClk;
  end
  parallel_byte_fifo_port u_parallel_byte_fifo_port (.core_clk(core_clk), .rst_n(rst_n),
    .linkClk(linkClk), .syncModeSel(syncModeSel), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady), .rdN(rdN),
    .wrN(wrN), .oeN(oeN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .rxfN(rxfN), .txeN(txeN), .clkOut(clkOut));
  host_strobe_model u_host_strobe_model (.core_clk(core_clk), .clkOut(clkOut), .rxfN(rxfN),
    .txeN(txeN), .dataOut(dataOut), .dataOe(dataOe), .rdN(rdN), .wrN(wrN), .oeN(oeN),
    .dataIn(dataIn));
  task automatic chkByte(input logic [BYTE_W-1:0] got, input logic [BYTE_W-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte
  task automatic chkBit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic pushRx(input logic [BYTE_W-1:0] b);
    int n;
    n = 0;
    @(negedge core_clk);
    rxData = b;
    rxValid = 1'h1;
    while (rxReady !== 1'h1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chkBit(rxReady, 1'h1);
    @(negedge core_clk);
    rxValid = 1'h0;
    chkBit(rxReady, 1'h0);
  endtask : pushRx
  task automatic takeTx(input logic [BYTE_W-1:0] e);
    int n;
    n = 0;
    @(negedge core_clk);
    while (txValid !== 1'h1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chkBit(txValid, 1'h1);
    chkByte(txData, e);
    txReady = 1'h1;
    @(negedge core_clk);
    txReady = 1'h0;
    chkBit(txValid, 1'h0);
  endtask : takeTx
  task automatic setMode(input logic m);
    @(negedge core_clk);
    syncModeSel = m;
    repeat (12) @(negedge core_clk);
  endtask : setMode
  initial
  begin
    repeat (16) @(negedge core_clk);
    chkBit(rxfN, 1'h1);
    chkBit(txeN, 1'h1);
    chkBit(dataOe, 1'h0);
    rst_n = 1'h1;
    foreach (ROWS[i])
    begin
      setMode(ROWS[i].m);
      pushRx(ROWS[i].rx);
      u_host_strobe_model.readByte(ROWS[i].m, 1'h0, rdB, rdOe);
      chkByte(rdB, ROWS[i].rx);
      chkBit(rdOe, 1'h1);
      u_host_strobe_model.writeByte(ROWS[i].m, ROWS[i].tx);
      chkBit(txeN, 1'h1);
      takeTx(ROWS[i].tx);
      chkBit(dataOe, 1'h0);
    end
    setMode(1'h0);
    u_host_strobe_model.readByte(1'h0, 1'h1, rdB, rdOe);
    chkByte(rdB, 8'h81);
    chkBit(rxfN, 1'h1);
    pushRx(8'h42);
    u_host_strobe_model.readByte(1'h0, 1'h0, rdB, rdOe);
    chkByte(rdB, 8'h42);
    pushRx(8'h24);
    repeat (7) @(negedge core_clk);
    chkBit(rxfN, 1'h1);
    u_host_strobe_model.readByte(1'h0, 1'h0, rdB, rdOe);
    chkByte(rdB, 8'h24);
    u_host_strobe_model.writeByte(1'h0, 8'h11);
    repeat (30) @(negedge core_clk);
    chkBit(txeN, 1'h1);
    takeTx(8'h11);
    @(negedge core_clk);
    chkBit(txeN, 1'h0);
    pushRx(8'h33);
    rst_n = 1'h0;
    repeat (4) @(negedge core_clk);
    chkBit(rxReady, 1'h1);
    chkBit(txValid, 1'h0);
    chkBit(rxfN, 1'h1);
    chkBit(dataOe, 1'h0);
    repeat (12) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (2) @(negedge core_clk);
    chkBit(rxfN, 1'h1);
    chkBit(txeN, 1'h0);
    pushRx(8'h5C);
    u_host_strobe_model.readByte(1'h0, 1'h0, rdB, rdOe);
    chkByte(rdB, 8'h5C);
    @(posedge linkClk);
    #2;
    chkBit(clkOut, 1'h1);
    @(negedge linkClk);
    #2;
    chkBit(clkOut, 1'h0);
    chkBit(u_host_strobe_model.stall, 1'h0);
    summarize();
  end
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
endmodule : test_parallel_byte_fifo_port
